// *** hw/tfd_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
module tfd_decoder #(
  parameter int BUF_DEPTH = 2
) (
  // Clock and reset
  input  wire logic                        core_clk_in,
  input  wire logic                        rst_b_in,
  // Host card bus pins
  input  wire logic                        low_byte_enable_n_in,
  input  wire logic                        high_byte_enable_n_in,
  input  wire logic                        io_read_strobe_n_in,
  input  wire logic                        io_write_strobe_n_in,
  input  wire logic                        reg_select_n_in,
  input  wire logic                        task_file_select_n_in,
  input  wire logic                        control_block_select_n_in,
  input  wire logic                        dma_grant_n_in,
  input  wire logic [10:0]                 host_addr_in,
  input  wire logic [15:0]                 host_data_in,
  output logic [15:0]                      host_data_out,
  output logic                             host_data_oe_out,
  output logic                             wide_io_indicate_n_out,
  // Configuration from the card core
  input  wire tfd_pkg::tfd_mode_type       mode_in,
  input  wire logic                        byte_pio_en_in,
  input  wire tfd_pkg::tfd_core_state_type core_state_in,
  // Read stream from the data buffer
  input  wire logic [15:0]                 rd_word_in,
  input  wire logic                        rd_valid_in,
  output logic                             rd_ready_out,
  // Write stream to the data buffer
  output logic [15:0]                      wr_word_out,
  output logic                             wr_valid_out,
  input  wire logic                        wr_ready_in,
  // Task file towards the core
  output tfd_pkg::tfd_taskfile_type        taskfile_out,
  output logic                             cmd_valid_out,
  output logic [7:0]                       cmd_code_out,
  output logic                             overrun_out
);
  import tfd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  tfd_pins_type     raw;
  tfd_pins_type     s1_q;
  tfd_pins_type     s2_q;
  logic             rd_prev_q;
  logic             wr_prev_q;
  logic             rd_ev;
  logic             wr_ev;
  tfd_decode_type   dec;
  logic             ide;
  logic             wide;
  logic             lo_only;
  logic             hi_only;
  logic             both;
  logic [3:0]       acc_off;
  logic             acc_ok;
  logic             acc_word;
  logic             acc_upper;
  logic             is_data;
  logic             word_data;
  logic             step_hi;
  logic             step_adv;
  logic             even_d;
  logic             odd_d;
  logic             even_q;
  logic             odd_q;
  logic             wide_n_q;
  logic [15:0]      src;
  logic [7:0]       reg_byte;
  logic [15:0]      rd_lane;
  logic [7:0]       wbyte;
  logic [7:0]       lo_byte_q;
  logic [7:0]       hi_byte_q;
  logic             push;
  logic [15:0]      push_word;
  logic             buf_ready;
  tfd_taskfile_type taskfile_q;

  assign raw = '{lo_en_n:   low_byte_enable_n_in,
                 hi_en_n:   high_byte_enable_n_in,
                 rd_n:      io_read_strobe_n_in,
                 wr_n:      io_write_strobe_n_in,
                 reg_sel_n: reg_select_n_in,
                 tf_sel_n:  task_file_select_n_in,
                 cb_sel_n:  control_block_select_n_in,
                 dma_n:     dma_grant_n_in,
                 addr:      host_addr_in,
                 data:      host_data_in};

  // All pins are synchronised together so address, enables and data seen
  // at a strobe edge belong to the same sample.
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s1_q      <= PINS_IDLE;
      s2_q      <= PINS_IDLE;
      rd_prev_q <= 1'b1;
      wr_prev_q <= 1'b1;
    end else begin
      s1_q      <= raw;
      s2_q      <= s1_q;
      rd_prev_q <= s2_q.rd_n;
      wr_prev_q <= s2_q.wr_n;
    end
  end

  // Reads act as the strobe falls; writes when it rises, data then settled.
  assign rd_ev   = rd_prev_q && !s2_q.rd_n;
  assign wr_ev   = !wr_prev_q && s2_q.wr_n;
  assign dec     = tfd_decode(mode_in, s2_q);
  assign ide     = mode_in == TFD_TRUE_IDE;
  assign wide    = !ide && dec.hit && tfd_is_data(dec.offset);
  assign lo_only = !s2_q.lo_en_n && s2_q.hi_en_n;
  assign hi_only = s2_q.lo_en_n && !s2_q.hi_en_n;
  assign both    = !s2_q.lo_en_n && !s2_q.hi_en_n;

  ////////////////////////////////////////////////////////////////////////////
  // The 16-bit indication is asserted only while the data register is hit.
  // Steering reads the live decode, because the registered pin lags the
  // address by a cycle and would judge a strobe by the previous address.
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wide_n_q <= 1'b1;
    end else begin
      wide_n_q <= !wide;
    end
  end
  assign wide_io_indicate_n_out = wide_n_q;

  always_comb begin
    acc_off   = dec.offset;
    acc_ok    = dec.hit;
    acc_word  = 1'b0;
    acc_upper = 1'b0;
    if (ide) begin
      acc_word = dec.dma ||
                 (tfd_is_data(dec.offset) && !byte_pio_en_in);
    end else if (both) begin
      acc_word = 1'b1;
      if (dec.offset == OFS_ERR_FEAT) begin
        acc_off = OFS_DATA;
      end
      if (dec.offset == OFS_DUP_ERR) begin
        acc_word  = 1'b0;
        acc_upper = 1'b1;
      end
    end else if (hi_only) begin
      acc_upper = 1'b1;
      if (!dec.offset[0]) begin
        if (wide) begin
          acc_off = dec.offset | OFS_ODD_MASK;
        end else begin
          acc_ok = 1'b0;
        end
      end
    end else if (!lo_only) begin
      acc_ok = 1'b0;
    end
  end

  assign is_data   = acc_ok && tfd_is_data(acc_off);
  assign word_data = is_data && acc_word;

  ////////////////////////////////////////////////////////////////////////////
  // Byte stepping: even_q marks an even byte taken, odd_q an odd byte taken
  // ahead of its even partner. Both clear when the word is finished.
  always_comb begin
    step_hi  = 1'b0;
    step_adv = word_data;
    even_d   = even_q;
    odd_d    = odd_q;
    if (word_data) begin
      even_d = 1'b0;
      odd_d  = 1'b0;
    end else if (is_data && acc_off == OFS_DUP_ODD) begin
      step_hi = 1'b1;
      if (even_q) begin
        step_adv = 1'b1;
        even_d   = 1'b0;
      end else begin
        odd_d = 1'b1;
      end
    end else if (is_data) begin
      if (odd_q) begin
        step_adv = 1'b1;
        odd_d    = 1'b0;
      end else if (even_q) begin
        step_hi  = 1'b1;
        step_adv = 1'b1;
        even_d   = 1'b0;
      end else begin
        even_d = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      even_q <= 1'b0;
      odd_q  <= 1'b0;
    end else if ((rd_ev || wr_ev) && is_data) begin
      even_q <= even_d;
      odd_q  <= odd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // An empty read stream returns zero rather than stalling the host.
  assign src = rd_valid_in ? rd_word_in : WORD_ZERO;

  always_comb begin
    case (acc_off)
      OFS_ERR_FEAT, OFS_DUP_ERR: reg_byte = core_state_in.error;
      OFS_COUNT:                 reg_byte = taskfile_q.count;
      OFS_BLK_LOW:               reg_byte = taskfile_q.blk_low;
      OFS_BLK_MID:               reg_byte = taskfile_q.blk_mid;
      OFS_BLK_HIGH:              reg_byte = taskfile_q.blk_high;
      OFS_HEAD:                  reg_byte = taskfile_q.head;
      OFS_STATCMD, OFS_ALT:      reg_byte = core_state_in.status;
      OFS_DRIVE:                 reg_byte = core_state_in.drive_addr;
      default:                   reg_byte = step_hi ? src[15:8] : src[7:0];
    endcase
    if (word_data) begin
      rd_lane = src;
    end else if (acc_upper) begin
      rd_lane = {reg_byte, BYTE_ZERO};
    end else begin
      rd_lane = {BYTE_ZERO, reg_byte};
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      host_data_out    <= WORD_ZERO;
      host_data_oe_out <= 1'b0;
    end else if (rd_ev && acc_ok) begin
      host_data_out    <= rd_lane;
      host_data_oe_out <= 1'b1;
    end else if (s2_q.rd_n) begin
      host_data_oe_out <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_ready_out <= 1'b0;
    end else begin
      rd_ready_out <= rd_ev && is_data && step_adv && rd_valid_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign wbyte     = acc_upper ? s2_q.data[15:8] : s2_q.data[7:0];
  assign push      = wr_ev && is_data && step_adv;
  assign push_word = word_data ? s2_q.data :
                     step_hi   ? {wbyte, lo_byte_q} : {hi_byte_q, wbyte};

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lo_byte_q <= BYTE_ZERO;
      hi_byte_q <= BYTE_ZERO;
    end else if (wr_ev && is_data && !word_data) begin
      if (step_hi) begin
        hi_byte_q <= wbyte;
      end else begin
        lo_byte_q <= wbyte;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      taskfile_q       <= '0;
      taskfile_q.count <= COUNT_RESET;
    end else if (wr_ev && acc_ok) begin
      case (acc_off)
        OFS_ERR_FEAT, OFS_DUP_ERR: taskfile_q.feature  <= wbyte;
        OFS_COUNT:                 taskfile_q.count    <= wbyte;
        OFS_BLK_LOW:               taskfile_q.blk_low  <= wbyte;
        OFS_BLK_MID:               taskfile_q.blk_mid  <= wbyte;
        OFS_BLK_HIGH:              taskfile_q.blk_high <= wbyte;
        OFS_HEAD:                  taskfile_q.head     <= wbyte;
        OFS_ALT:                   taskfile_q.control  <= wbyte;
        default:                   taskfile_q          <= taskfile_q;
      endcase
    end
  end
  assign taskfile_out = taskfile_q;

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cmd_valid_out <= 1'b0;
      cmd_code_out  <= BYTE_ZERO;
    end else begin
      cmd_valid_out <= wr_ev && acc_ok && acc_off == OFS_STATCMD;
      if (wr_ev && acc_ok && acc_off == OFS_STATCMD) begin
        cmd_code_out <= wbyte;
      end
    end
  end

  // The host cannot be stalled, so a push into a full buffer is flagged.
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      overrun_out <= 1'b0;
    end else if (push && !buf_ready) begin
      overrun_out <= 1'b1;
    end
  end

  tfd_buffer #(
    .WIDTH (16),
    .DEPTH (BUF_DEPTH)
  ) u_wbuf (
    .core_clk_in   (core_clk_in),
    .rst_b_in      (rst_b_in),
    .in_data_in    (push_word),
    .in_valid_in   (push),
    .in_ready_out  (buf_ready),
    .out_data_out  (wr_word_out),
    .out_valid_out (wr_valid_out),
    .out_ready_in  (wr_ready_in)
  );

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence s_odd_first;
    rd_ev && is_data && !word_data && !acc_upper &&
    acc_off == OFS_DUP_ODD && !even_q && !odd_q;
  endsequence

  sequence s_even_after;
    rd_ev && is_data && !word_data && acc_off != OFS_DUP_ODD;
  endsequence

  word_lane_a: assert property (
    (rd_ev && !ide && both && dec.hit && dec.offset == OFS_DATA &&
     rd_valid_in) |=> host_data_out == $past(rd_word_in) && host_data_oe_out)
    else $error("word at offset zero not on full bus");

  word_adv_a: assert property (
    (rd_ev && word_data && rd_valid_in) |=> rd_ready_out ##1 !rd_ready_out)
    else $error("word access did not consume one buffer word");

  byte_pair_a: assert property (
    (rd_ev && !ide && lo_only && dec.hit && acc_off == OFS_DATA &&
     !even_q && !odd_q && rd_valid_in) |=> !rd_ready_out && even_q &&
     host_data_out == {BYTE_ZERO, $past(rd_word_in[7:0])})
    else $error("first byte at offset zero not the even byte");

  err_upper_a: assert property (
    (rd_ev && !ide && hi_only && dec.hit && dec.offset == OFS_DATA &&
     wide) |=> host_data_out == {$past(core_state_in.error), BYTE_ZERO})
    else $error("high enable at offset zero did not read error");

  odd_first_a: assert property (
    s_odd_first |=> odd_q && !rd_ready_out &&
    host_data_out[7:0] == $past(src[15:8]))
    else $error("offset nine byte was not the odd byte");

  even_second_a: assert property (
    ((odd_q && rd_valid_in) and s_even_after) |=> rd_ready_out && !odd_q)
    else $error("even byte after odd did not finish the word");

  alt_pair_a: assert property (
    (rd_ev && is_data && !word_data && acc_off == OFS_DUP_ODD && even_q &&
     rd_valid_in) |=> rd_ready_out && !even_q)
    else $error("eight then nine did not step to next word");

  word_off1_a: assert property (
    (rd_ev && !ide && both && dec.hit && dec.offset == OFS_ERR_FEAT &&
     rd_valid_in) |=> rd_ready_out)
    else $error("word at offset one not treated as data");

  dma_word_a: assert property (
    (rd_ev && ide && dec.dma && rd_valid_in) |=>
    host_data_out == $past(rd_word_in) && rd_ready_out)
    else $error("dma read not a full word");

  byte_pio_a: assert property (
    (rd_ev && ide && byte_pio_en_in && dec.hit && !dec.dma &&
     dec.offset == OFS_DATA) |=> host_data_out[15:8] == BYTE_ZERO)
    else $error("byte pio data used upper lanes");

  cmd_pulse_a: assert property (
    (wr_ev && acc_ok && acc_off == OFS_STATCMD) |=>
    cmd_valid_out && cmd_code_out == $past(wbyte) ##1 !cmd_valid_out)
    else $error("command write did not pulse once");

  reserved_a: assert property (
    (wr_ev && acc_ok && acc_off == OFS_DRIVE) |=>
    $stable(taskfile_out) && !cmd_valid_out)
    else $error("write to offset F changed state");

endmodule
`default_nettype wire

// *** hw/tfd_pkg.sv ***
package tfd_pkg;

  localparam logic [3:0] OFS_DATA     = 4'h0;
  localparam logic [3:0] OFS_ERR_FEAT = 4'h1;
  localparam logic [3:0] OFS_COUNT    = 4'h2;
  localparam logic [3:0] OFS_BLK_LOW  = 4'h3;
  localparam logic [3:0] OFS_BLK_MID  = 4'h4;
  localparam logic [3:0] OFS_BLK_HIGH = 4'h5;
  localparam logic [3:0] OFS_HEAD     = 4'h6;
  localparam logic [3:0] OFS_STATCMD  = 4'h7;
  localparam logic [3:0] OFS_DUP_EVEN = 4'h8;
  localparam logic [3:0] OFS_DUP_ODD  = 4'h9;
  localparam logic [3:0] OFS_GAP_LO   = 4'hA;
  localparam logic [3:0] OFS_GAP_HI   = 4'hC;
  localparam logic [3:0] OFS_DUP_ERR  = 4'hD;
  localparam logic [3:0] OFS_ALT      = 4'hE;
  localparam logic [3:0] OFS_DRIVE    = 4'hF;
  localparam logic [3:0] OFS_ODD_MASK = 4'h1;

  localparam logic [5:0] PRI_TASK_HI  = 6'h1F;
  localparam logic [5:0] SEC_TASK_HI  = 6'h17;
  localparam logic [5:0] PRI_CTRL_HI  = 6'h3F;
  localparam logic [5:0] SEC_CTRL_HI  = 6'h37;
  localparam logic [3:0] CTRL_ALT_NIB = 4'h6;
  localparam logic [3:0] CTRL_DRV_NIB = 4'h7;
  localparam logic [2:0] IDE_ALT_ADDR = 3'h6;
  localparam logic [2:0] IDE_DRV_ADDR = 3'h7;

  localparam logic [7:0]  BYTE_ZERO   = 8'h00;
  localparam logic [7:0]  COUNT_RESET = 8'h01;
  localparam logic [15:0] WORD_ZERO   = 16'h0000;

  typedef enum logic [1:0] {
    TFD_CONTIG   = 2'b00,
    TFD_PRISEC   = 2'b01,
    TFD_TRUE_IDE = 2'b11
  } tfd_mode_type;

  typedef struct packed {
    logic        lo_en_n;
    logic        hi_en_n;
    logic        rd_n;
    logic        wr_n;
    logic        reg_sel_n;
    logic        tf_sel_n;
    logic        cb_sel_n;
    logic        dma_n;
    logic [10:0] addr;
    logic [15:0] data;
  } tfd_pins_type;

  localparam tfd_pins_type PINS_IDLE =
    '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 11'h000, 16'h0000};

  typedef struct packed {
    logic       hit;
    logic       dma;
    logic [3:0] offset;
  } tfd_decode_type;

  typedef struct packed {
    logic [7:0] feature;
    logic [7:0] count;
    logic [7:0] blk_low;
    logic [7:0] blk_mid;
    logic [7:0] blk_high;
    logic [7:0] head;
    logic [7:0] control;
  } tfd_taskfile_type;

  typedef struct packed {
    logic [7:0] error;
    logic [7:0] status;
    logic [7:0] drive_addr;
  } tfd_core_state_type;

  function automatic logic tfd_is_data(input logic [3:0] off);
    return off inside {OFS_DATA, OFS_DUP_EVEN, OFS_DUP_ODD};
  endfunction

  function automatic tfd_decode_type tfd_decode(input tfd_mode_type mode,
                                                input tfd_pins_type p);
    tfd_decode_type d;
    logic [5:0]     hi;
    d  = '{hit: 1'b0, dma: 1'b0, offset: OFS_DATA};
    hi = p.addr[9:4];
    unique case (mode)
      TFD_CONTIG: begin
        d.hit    = !p.reg_sel_n &&
                   !(p.addr[3:0] >= OFS_GAP_LO && p.addr[3:0] <= OFS_GAP_HI);
        d.offset = p.addr[3:0];
      end
      TFD_PRISEC: begin
        if (!p.reg_sel_n && !p.addr[3] &&
            (hi == PRI_TASK_HI || hi == SEC_TASK_HI)) begin
          d.hit    = 1'b1;
          d.offset = {1'b0, p.addr[2:0]};
        end else if (!p.reg_sel_n &&
                     (hi == PRI_CTRL_HI || hi == SEC_CTRL_HI) &&
                     p.addr[3:0] inside {CTRL_ALT_NIB, CTRL_DRV_NIB}) begin
          d.hit    = 1'b1;
          d.offset = (p.addr[3:0] == CTRL_DRV_NIB) ? OFS_DRIVE : OFS_ALT;
        end
      end
      TFD_TRUE_IDE: begin
        if (!p.dma_n && p.tf_sel_n && p.cb_sel_n) begin
          d.hit = 1'b1;
          d.dma = 1'b1;
        end else if (p.dma_n && !p.tf_sel_n && p.cb_sel_n) begin
          d.hit    = 1'b1;
          d.offset = {1'b0, p.addr[2:0]};
        end else if (p.dma_n && p.tf_sel_n && !p.cb_sel_n &&
                     p.addr[2:0] inside {IDE_ALT_ADDR, IDE_DRV_ADDR}) begin
          d.hit    = 1'b1;
          d.offset = (p.addr[2:0] == IDE_DRV_ADDR) ? OFS_DRIVE : OFS_ALT;
        end
      end
      default: d.hit = 1'b0;
    endcase
    return d;
  endfunction

endpackage

// *** hw/tfd_buffer.sv ***
`timescale 1ns/1ps
`default_nettype none
// Shift buffer: entry 0 is always the head, so the output is a register.
module tfd_buffer #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             rst_b_in,
  // Filling side
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  // Draining side
  output logic [WIDTH-1:0]      out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [DEPTH-1:0] vld_q;
  logic [CW-1:0]    count_q;
  logic [CW-1:0]    count_d;
  logic [CW-1:0]    slot;
  logic             push;
  logic             pop;

  assign in_ready_out  = !vld_q[DEPTH-1];
  assign out_valid_out = vld_q[0];
  assign out_data_out  = mem_q[0];
  assign pop           = vld_q[0] && out_ready_in;
  assign push          = in_valid_in && in_ready_out;
  assign slot          = pop ? count_q - 1'b1 : count_q;

  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        mem_q[i] <= '0;
        vld_q[i] <= 1'b0;
      end else begin
        vld_q[i] <= CW'(i) < count_d;
        if (push && slot == CW'(i)) begin
          mem_q[i] <= in_data_in;
        end else if (pop) begin
          mem_q[i] <= (i < DEPTH - 1) ? mem_q[(i + 1) % DEPTH] : mem_q[i];
        end
      end
    end
  end

endmodule
`default_nettype wire

// *** tb/tfd_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Core side of the data path: counting read words, a write sink that stalls.
module tfd_core_model (
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_b_in,
  // Read stream
  output logic [15:0]      rd_word_out,
  output logic             rd_valid_out,
  input  wire logic        rd_ready_in,
  // Write stream
  input  wire logic [15:0] wr_word_in,
  input  wire logic        wr_valid_in,
  output logic             wr_ready_out,
  output logic [15:0]      last_wr_out
);
  logic [3:0] cnt_q;
  // Each word differs in both bytes, so a lane or order slip shows.
  assign rd_word_out  = {4'hB, cnt_q, 4'hA, cnt_q};
  assign rd_valid_out = 1'b1;
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_q        <= 4'h0;
      wr_ready_out <= 1'b0;
      last_wr_out  <= 16'h0000;
    end else begin
      // Ready every other cycle, so the write buffer must hold words.
      wr_ready_out <= !wr_ready_out;
      if (rd_ready_in) cnt_q <= cnt_q + 4'h1;
      if (wr_valid_in && wr_ready_out) last_wr_out <= wr_word_in;
    end
  end
endmodule
`default_nettype wire

// *** tb/task_file_address_decoder_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module task_file_address_decoder_tb_top;
  import tfd_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, lo_n = 1'b1, hi_n = 1'b1;
  logic rd_n = 1'b1, wr_n = 1'b1, oe, oe_v, rdy, rval, wv, wrdy;
  logic [10:0] addr = 11'h000;
  logic [15:0] din = 16'h0000, dout, rdw, wrw, last_wr, rd_v;
  logic [7:0] code;
  logic cs0_n = 1'b1, cs1_n = 1'b1, dack_n = 1'b1, bpio = 1'b0, wide_n, ovr;
  tfd_mode_type mode = TFD_CONTIG;
  tfd_taskfile_type tf, tf_old;
  int fail_count = 0, checked = 0;
  always #20 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  // Register select stays low: the card is used in I/O mode, then in True IDE mode, where it is ignored.
  tfd_decoder u_tfd_decoder (.core_clk_in(clk), .rst_b_in(rst_b),
    .low_byte_enable_n_in(lo_n), .high_byte_enable_n_in(hi_n),
    .io_read_strobe_n_in(rd_n), .io_write_strobe_n_in(wr_n),
    .reg_select_n_in(1'b0), .task_file_select_n_in(cs0_n),
    .control_block_select_n_in(cs1_n), .dma_grant_n_in(dack_n),
    .host_addr_in(addr), .host_data_in(din), .host_data_out(dout),
    .host_data_oe_out(oe), .wide_io_indicate_n_out(wide_n), .mode_in(mode),
    .byte_pio_en_in(bpio), .core_state_in(24'h5A500F),
    .rd_word_in(rdw), .rd_valid_in(rval), .rd_ready_out(rdy),
    .wr_word_out(wrw), .wr_valid_out(wv), .wr_ready_in(wrdy),
    .taskfile_out(tf), .cmd_valid_out(), .cmd_code_out(code),
    .overrun_out(ovr));
  tfd_core_model u_tfd_core_model (.core_clk_in(clk), .rst_b_in(rst_b),
    .rd_word_out(rdw), .rd_valid_out(rval), .rd_ready_in(rdy),
    .wr_word_in(wrw), .wr_valid_in(wv), .wr_ready_out(wrdy),
    .last_wr_out(last_wr));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch at %0t: saw %h, want %h", $time, s, e);
    end
  endtask
  // Strobe low and high five clocks each, well over the three the sync needs.
  task automatic acc(input logic w, input logic [1:0] en,
                     input logic [10:0] a, input logic [15:0] d);
    {hi_n, lo_n} = en;
    addr = a;
    din = d;
    rd_n = w;
    wr_n = !w;
    repeat (5) @(posedge clk);
    #1;
    oe_v = oe;
    rd_v = dout;
    rd_n = 1'b1;
    wr_n = 1'b1;
    repeat (5) @(posedge clk);
    #1;
  endtask
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Offset 9 is byte-read twice in a row, the second read starting a new word with its odd byte.
  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst_b = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(tf.count, 8'h01);
    acc(0, 2'b00, 11'h000, 0);
    chk(rd_v, 16'hB0A0);
    acc(0, 2'b00, 11'h001, 0);
    chk(rd_v, 16'hB1A1);
    acc(0, 2'b10, 11'h000, 0);
    chk(rd_v[7:0], 8'hA2);
    acc(0, 2'b10, 11'h000, 0);
    chk(rd_v[7:0], 8'hB2);
    acc(0, 2'b10, 11'h008, 0);
    chk(rd_v[7:0], 8'hA3);
    acc(0, 2'b10, 11'h009, 0);
    chk(rd_v[7:0], 8'hB3);
    acc(0, 2'b10, 11'h009, 0);
    chk(rd_v[7:0], 8'hB4);
    acc(0, 2'b10, 11'h008, 0);
    chk(rd_v[7:0], 8'hA4);
    acc(0, 2'b01, 11'h000, 0);
    chk(rd_v[15:8], 8'h5A);
    acc(0, 2'b00, 11'h00D, 0);
    chk(rd_v[15:8], 8'h5A);
    acc(0, 2'b10, 11'h7F7, 0);
    chk(rd_v[7:0], 8'h50);
    acc(0, 2'b10, 11'h00E, 0);
    chk(rd_v[7:0], 8'h50);
    chk(wide_n, 1'b1);
    acc(0, 2'b10, 11'h00F, 0);
    chk(rd_v[7:0], 8'h0F);
    acc(0, 2'b10, 11'h00A, 0);
    chk(oe_v, 1'b0);
    acc(0, 2'b01, 11'h008, 0);
    chk(rd_v[15:8], 8'hB5);
    chk(wide_n, 1'b0);
    acc(1, 2'b10, 11'h002, 16'h003C);
    chk(tf.count, 8'h3C);
    acc(1, 2'b10, 11'h007, 16'h00EC);
    chk(code, 8'hEC);
    tf_old = tf;
    acc(1, 2'b10, 11'h00F, 16'h0077);
    chk(16'(tf !== tf_old), 16'h0000);
    acc(1, 2'b00, 11'h000, 16'h1234);
    chk(last_wr, 16'h1234);
    acc(1, 2'b10, 11'h000, 16'h0056);
    acc(1, 2'b10, 11'h000, 16'h0078);
    chk(last_wr, 16'h7856);
    mode = TFD_PRISEC;
    acc(0, 2'b10, 11'h1F7, 0);
    chk(rd_v[7:0], 8'h50);
    acc(0, 2'b10, 11'h376, 0);
    chk(rd_v[7:0], 8'h50);
    acc(0, 2'b10, 11'h2F7, 0);
    chk(oe_v, 1'b0);
    chk(ovr, 1'b0);
    mode = TFD_TRUE_IDE;
    cs0_n = 1'b0;
    acc(0, 2'b00, 11'h007, 0);
    chk(rd_v, 16'h0050);
    cs0_n = 1'b1;
    cs1_n = 1'b0;
    acc(0, 2'b00, 11'h006, 0);
    chk(rd_v, 16'h0050);
    cs1_n = 1'b1;
    dack_n = 1'b0;
    acc(0, 2'b00, 11'h3FF, 0);
    chk(rd_v, 16'hB5A5);
    dack_n = 1'b1;
    cs0_n = 1'b0;
    bpio = 1'b1;
    acc(0, 2'b00, 11'h000, 0);
    chk(rd_v, 16'h00A6);
    report_and_stop();
  end
endmodule
`default_nettype wire
